// ### hw/smsr_pkg.sv
package smsr_pkg;
  // ----------------------------------------------------------------
  // register offsets (8-bit address space)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_SYS_CTL = 8'h00;
  localparam logic [7:0] A_LO_CTL = 8'h01;
  localparam logic [7:0] A_UP_CTL = 8'h02;
  localparam logic [7:0] A_LO_CMP = 8'h03;
  localparam logic [7:0] A_UP_CMP = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h05;
  localparam logic [7:0] A_IRQ_MASK = 8'h06;
  localparam logic [7:0] A_RST_CAUSE = 8'h07;
  localparam logic [7:0] A_MODE_STAT = 8'h08;
  localparam logic [7:0] A_MISC = 8'h09;
  // ----------------------------------------------------------------
  // system_control_two fields and reset value
  // ----------------------------------------------------------------
  localparam int B_FAST_EN = 7;
  localparam int B_SLOW_EN = 6;
  localparam int B_CLK_SEL = 5;
  localparam logic [7:0] SYS_CTL_RST = 8'h80;
  localparam logic [7:0] SYS_CTL_WMASK = 8'hE0;
  // ----------------------------------------------------------------
  // warm-up counter codes
  // ----------------------------------------------------------------
  localparam logic [7:0] UP_WARMUP = 8'h05;
  localparam int B_UP_START = 3;
  localparam logic [7:0] UP_MODE_MASK = 8'hF7;
  localparam logic [7:0] LO_CASC_FC = 8'h63;
  localparam logic [7:0] LO_CASC_FS = 8'h43;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hFF;
  // ----------------------------------------------------------------
  // interrupt and reset cause bits
  // ----------------------------------------------------------------
  localparam int B_IRQ_WARMUP = 0;
  localparam int B_IRQ_SWITCH = 1;
  localparam int B_RC_EXT = 0;
  localparam int B_RC_TRAP = 1;
  localparam int B_RC_WDT = 2;
  localparam int B_RC_CLK = 3;
  localparam int B_MISC_WDT_EN = 0;
  localparam logic [7:0] MISC_RST = 8'h01;
  // ----------------------------------------------------------------
  // clock division and reset timing
  // ----------------------------------------------------------------
  localparam int PRE_W = 6;
  localparam logic [1:0] FC_PHASE_LAST = 2'h3;
  localparam logic [PRE_W-1:0] FS_PHASE_LAST = 6'h3F;
  localparam int EXT_RST_FC = 12;
  localparam int MALF_RST_FC = 24;
  localparam logic [4:0] EXT_RST_CNT = 5'(EXT_RST_FC);
  localparam logic [4:0] MALF_RST_CNT = 5'(MALF_RST_FC);
  localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
  typedef enum logic [1:0] {
    SMSR_FAST_SINGLE = 2'b00,
    SMSR_FAST_DUAL = 2'b01,
    SMSR_SLOW_ON = 2'b10,
    SMSR_SLOW_OFF = 2'b11
  } smsr_mode_e;
endpackage

// ### hw/smsr_top.sv
`timescale 1ns/1ps
module smsr_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic reset_pin_n_i,
  input wire logic addr_trap_i,
  input wire logic wdt_fault_i,
  input wire logic [7:0] vec_lo_i,
  input wire logic [7:0] vec_hi_i,
  output logic core_ce_o,
  output logic fast_osc_en_o,
  output logic slow_osc_en_o,
  output smsr_pkg::smsr_mode_e mode_o,
  output logic core_rst_n_o,
  output logic int_state_clear_o,
  output logic [15:0] pc_o,
  output logic pc_load_o,
  output logic watchdog_en_o,
  output logic warmup_done_o,
  output logic irq_o
);
  import smsr_pkg::*;

  logic [7:0] sys_ctl;
  logic [7:0] lo_ctl;
  logic [7:0] up_ctl;
  logic [7:0] lo_cmp;
  logic [7:0] up_cmp;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic [7:0] rst_cause;
  logic [7:0] misc;
  logic [PRE_W-1:0] prescale;
  logic [4:0] ext_cnt;
  logic [4:0] malf_cnt;
  logic ext_active;
  logic in_rst;
  logic in_rst_q;
  logic clk_slow;
  logic [15:0] wu_cnt;
  logic wu_event;
  logic switch_event;
  logic clk_fault;
  logic fc_raw;
  logic fc_tick;
  logic fs_tick;
  logic src_tick;
  logic wu_run;
  logic wr_sys;
  logic malf_req;
  logic [1:0] rst_phase;
  logic rst_tick;

  // ----------------------------------------------------------------
  // prescaler and clock enables
  // ----------------------------------------------------------------
  // fs phase end always coincides with an fc phase end, so a source
  // change there never cuts a phase short
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  assign fc_raw = (prescale[1:0] == FC_PHASE_LAST);
  assign fc_tick = fc_raw && sys_ctl[B_FAST_EN];
  assign fs_tick = (prescale == FS_PHASE_LAST) && sys_ctl[B_SLOW_EN];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      clk_slow <= 1'b0;
    end else if (fs_tick) begin
      clk_slow <= sys_ctl[B_CLK_SEL];
    end
  end

  assign switch_event = fs_tick && (clk_slow != sys_ctl[B_CLK_SEL]);
  assign core_ce_o = clk_slow ? fs_tick : fc_tick;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      mode_o <= SMSR_FAST_SINGLE;
    end else if (clk_slow) begin
      mode_o <= sys_ctl[B_FAST_EN] ? SMSR_SLOW_ON : SMSR_SLOW_OFF;
    end else begin
      mode_o <= sys_ctl[B_SLOW_EN] ? SMSR_FAST_DUAL : SMSR_FAST_SINGLE;
    end
  end

  // ----------------------------------------------------------------
  // system control register
  // ----------------------------------------------------------------
  assign wr_sys = wr_i && (addr_i == A_SYS_CTL);
  // a write that would leave the selected clock without oscillator
  assign clk_fault = wr_sys && ((!wdata_i[B_FAST_EN] && !wdata_i[B_SLOW_EN]) ||
                     (!wdata_i[B_FAST_EN] && !wdata_i[B_CLK_SEL]) ||
                     (!wdata_i[B_SLOW_EN] && wdata_i[B_CLK_SEL]));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      sys_ctl <= SYS_CTL_RST;
    end else if (wr_sys && !clk_fault) begin
      sys_ctl <= wdata_i & SYS_CTL_WMASK;
    end
  end

  assign fast_osc_en_o = sys_ctl[B_FAST_EN];
  assign slow_osc_en_o = sys_ctl[B_SLOW_EN];

  // ----------------------------------------------------------------
  // warm-up counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      lo_ctl <= CTL_RST;
      up_ctl <= CTL_RST;
      lo_cmp <= CMP_RST;
      up_cmp <= CMP_RST;
    end else if (wr_i) begin
      if (addr_i == A_LO_CTL) begin
        lo_ctl <= wdata_i;
      end
      if (addr_i == A_UP_CTL) begin
        up_ctl <= wdata_i;
      end
      if (addr_i == A_LO_CMP) begin
        lo_cmp <= wdata_i;
      end
      if (addr_i == A_UP_CMP) begin
        up_cmp <= wdata_i;
      end
    end
  end

  assign wu_run = up_ctl[B_UP_START] && ((up_ctl & UP_MODE_MASK) == UP_WARMUP);
  assign src_tick = (lo_ctl == LO_CASC_FC) ? fc_tick :
                    (lo_ctl == LO_CASC_FS) ? fs_tick : 1'b0;
  assign wu_event = wu_run && src_tick && (wu_cnt == {up_cmp, lo_cmp});

  // the count restarts after each match so a forgotten stop repeats
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst || !wu_run) begin
      wu_cnt <= '0;
    end else if (src_tick) begin
      wu_cnt <= wu_event ? 16'h0000 : wu_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      warmup_done_o <= 1'b0;
    end else begin
      warmup_done_o <= wu_event;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      irq_stat <= 8'h00;
    end else begin
      if (wr_i && (addr_i == A_IRQ_STAT)) begin
        irq_stat <= irq_stat & ~wdata_i;
      end
      // set wins over a clear in the same cycle
      if (wu_event) begin
        irq_stat[B_IRQ_WARMUP] <= 1'b1;
      end
      if (switch_event) begin
        irq_stat[B_IRQ_SWITCH] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      irq_mask <= 8'h00;
    end else if (wr_i && (addr_i == A_IRQ_MASK)) begin
      irq_mask <= wdata_i;
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // reset generation
  // ----------------------------------------------------------------
  // own fc phase: the prescaler is held clear during reset, so it
  // cannot time the reset that holds it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rst_phase <= 2'h0;
    end else begin
      rst_phase <= rst_phase + 2'h1;
    end
  end

  assign rst_tick = (rst_phase == FC_PHASE_LAST);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || reset_pin_n_i) begin
      ext_cnt <= 5'h00;
      ext_active <= 1'b0;
    end else if (rst_tick) begin
      if (ext_cnt == EXT_RST_CNT - 5'h01) begin
        ext_active <= 1'b1;
      end else begin
        ext_cnt <= ext_cnt + 5'h01;
      end
    end
  end

  assign malf_req = addr_trap_i || wdt_fault_i || clk_fault;

  // power-on loads the full stretch, giving the allowed spurious pulse
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      malf_cnt <= MALF_RST_CNT;
    end else if (malf_req) begin
      malf_cnt <= MALF_RST_CNT;
    end else if (rst_tick && (malf_cnt != 5'h00)) begin
      malf_cnt <= malf_cnt - 5'h01;
    end
  end

  assign in_rst = ext_active || (malf_cnt != 5'h00);
  assign core_rst_n_o = !in_rst;
  assign int_state_clear_o = in_rst;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rst_cause <= 8'h00;
    end else begin
      if (wr_i && (addr_i == A_RST_CAUSE)) begin
        rst_cause <= rst_cause & ~wdata_i;
      end
      if (ext_active) begin
        rst_cause[B_RC_EXT] <= 1'b1;
      end
      if (addr_trap_i) begin
        rst_cause[B_RC_TRAP] <= 1'b1;
      end
      if (wdt_fault_i) begin
        rst_cause[B_RC_WDT] <= 1'b1;
      end
      if (clk_fault) begin
        rst_cause[B_RC_CLK] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      in_rst_q <= 1'b1;
      pc_o <= RESET_VEC_ADDR;
      pc_load_o <= 1'b0;
    end else begin
      in_rst_q <= in_rst;
      pc_load_o <= in_rst_q && !in_rst;
      if (in_rst_q && !in_rst) begin
        pc_o <= {vec_hi_i, vec_lo_i};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || in_rst) begin
      misc <= MISC_RST;
    end else if (wr_i && (addr_i == A_MISC)) begin
      misc <= wdata_i & MISC_RST;
    end
  end

  assign watchdog_en_o = misc[B_MISC_WDT_EN];

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        A_SYS_CTL: rdata_o <= sys_ctl;
        A_LO_CTL: rdata_o <= lo_ctl;
        A_UP_CTL: rdata_o <= up_ctl;
        A_LO_CMP: rdata_o <= lo_cmp;
        A_UP_CMP: rdata_o <= up_cmp;
        A_IRQ_STAT: rdata_o <= irq_stat;
        A_IRQ_MASK: rdata_o <= irq_mask;
        A_RST_CAUSE: rdata_o <= rst_cause;
        A_MODE_STAT: rdata_o <= {5'h00, clk_slow, mode_o};
        A_MISC: rdata_o <= misc;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// ### sim/slow_mode_switch_and_reset_tb_top.sv
`timescale 1ns/1ps
module slow_mode_switch_and_reset_tb_top;
  import smsr_pkg::*;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic reset_pin_n_i = 1'b1, addr_trap_i = 1'b0, wdt_fault_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, vec_lo_i = 8'h34, vec_hi_i = 8'h12;
  logic [7:0] rdata_o;
  logic core_ce_o, fast_osc_en_o, slow_osc_en_o, core_rst_n_o, int_state_clear_o;
  logic pc_load_o, watchdog_en_o, warmup_done_o, irq_o;
  logic [15:0] pc_o;
  smsr_mode_e mode_o;
  int fail_count = 0, n_tests = 0, cyc = 0, n, k;
  always #5 mclk_i = ~mclk_i;
  smsr_top smsr_top_i (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .reset_pin_n_i(reset_pin_n_i),
    .addr_trap_i(addr_trap_i),
    .wdt_fault_i(wdt_fault_i),
    .vec_lo_i(vec_lo_i),
    .vec_hi_i(vec_hi_i),
    .core_ce_o(core_ce_o),
    .fast_osc_en_o(fast_osc_en_o),
    .slow_osc_en_o(slow_osc_en_o),
    .mode_o(mode_o),
    .core_rst_n_o(core_rst_n_o),
    .int_state_clear_o(int_state_clear_o),
    .pc_o(pc_o),
    .pc_load_o(pc_load_o),
    .watchdog_en_o(watchdog_en_o),
    .warmup_done_o(warmup_done_o),
    .irq_o(irq_o)
  );
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(16'(rdata_o), 16'(exp));
  endtask
  task automatic wait_mode(input smsr_mode_e m);
    n = 0;
    while (mode_o !== m && n < 150) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(16'(mode_o), 16'(m));
  endtask
  // pc load pulse marks the end of any internal reset
  task automatic wait_rel;
    n = 0;
    while (pc_load_o !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(pc_o, {vec_hi_i, vec_lo_i});
    chk({watchdog_en_o, 6'h00, mode_o}, {1'b1, 6'h00, SMSR_FAST_SINGLE});
  endtask
  task automatic wait_done;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (warmup_done_o !== 1'b1 && n < 400);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wait_rel();
    rd(A_SYS_CTL, SYS_CTL_RST);
    rd(8'hFF, 8'h00);
    rd(A_MISC, MISC_RST);
    wr(A_SYS_CTL, 8'hC0);
    wait_mode(SMSR_FAST_DUAL);
    chk(16'({fast_osc_en_o, slow_osc_en_o}), 16'h0003);
    wr(A_LO_CMP, 8'h03);
    wr(A_UP_CMP, 8'h00);
    wr(A_LO_CTL, LO_CASC_FC);
    wr(A_UP_CTL, UP_WARMUP | 8'h08);
    wait_done();
    wait_done();
    chk(16'(n), 16'h0010);
    wr(A_LO_CTL, LO_CASC_FS);
    wait_done();
    wait_done();
    chk(16'(n), 16'h0100);
    wr(A_UP_CTL, CTL_RST);
    rd(A_IRQ_STAT, 8'h01);
    chk(16'(irq_o), 16'h0000);
    wr(A_IRQ_MASK, 8'h01);
    #1;
    chk(16'(irq_o), 16'h0001);
    wr(A_IRQ_STAT, 8'h01);
    #1;
    chk(16'(irq_o), 16'h0000);
    wr(A_SYS_CTL, 8'hE0);
    wait_mode(SMSR_SLOW_ON);
    rd(A_IRQ_STAT, 8'h02);
    wr(A_SYS_CTL, 8'h60);
    wait_mode(SMSR_SLOW_OFF);
    chk(16'({fast_osc_en_o, slow_osc_en_o}), 16'h0001);
    rd(A_MODE_STAT, 8'h07);
    wr(A_SYS_CTL, 8'hE0);
    wr(A_SYS_CTL, 8'hC0);
    #1;
    chk(16'(mode_o), 16'(SMSR_SLOW_ON));
    wait_mode(SMSR_FAST_DUAL);
    wr(A_RST_CAUSE, 8'hFF);
    wr(A_MISC, 8'h00);
    #1;
    chk(16'(watchdog_en_o), 16'h0000);
    wr(A_SYS_CTL, 8'h40);
    wait_rel();
    rd(A_RST_CAUSE, 8'h08);
    for (k = 0; k < 2; k++) begin
      wr(A_RST_CAUSE, 8'hFF);
      @(posedge mclk_i);
      addr_trap_i <= (k == 0);
      wdt_fault_i <= (k == 1);
      @(posedge mclk_i);
      addr_trap_i <= 1'b0;
      wdt_fault_i <= 1'b0;
      wait_rel();
      rd(A_RST_CAUSE, 8'h02 << k);
    end
    wr(A_SYS_CTL, 8'hE0);
    wait_mode(SMSR_SLOW_ON);
    wr(A_RST_CAUSE, 8'hFF);
    reset_pin_n_i <= 1'b0;
    vec_lo_i <= 8'hA5;
    repeat (20) @(posedge mclk_i);
    reset_pin_n_i <= 1'b1;
    #1;
    chk(16'(core_rst_n_o), 16'h0001);
    @(posedge mclk_i);
    reset_pin_n_i <= 1'b0;
    repeat (80) @(posedge mclk_i);
    reset_pin_n_i <= 1'b1;
    #1;
    chk(16'(core_rst_n_o), 16'h0000);
    wait_rel();
    rd(A_RST_CAUSE, 8'h01);
    report_and_stop();
  end
endmodule

// ### sim/smsr_monitor.sv
`timescale 1ns/1ps
module smsr_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_n_i,
  input wire logic addr_trap_i,
  input wire logic wdt_fault_i,
  input wire logic [7:0] vec_lo_i,
  input wire logic [7:0] vec_hi_i,
  input wire logic core_ce_o,
  input wire logic fast_osc_en_o,
  input wire smsr_pkg::smsr_mode_e mode_o,
  input wire logic core_rst_n_o,
  input wire logic int_state_clear_o,
  input wire logic [15:0] pc_o,
  input wire logic pc_load_o,
  input wire logic watchdog_en_o
);
  import smsr_pkg::*;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----
  // reset and clock checks
  // ----
  AST_CLR_LEVEL:
    assert property (int_state_clear_o != core_rst_n_o) else $error("clear level wrong");
  AST_PC_LOAD:
    assert property ($rose(core_rst_n_o) |-> ##[0:1] pc_load_o) else $error("no pc load");
  AST_PC_VEC:
    assert property (pc_load_o |-> pc_o == {vec_hi_i, vec_lo_i}) else $error("pc not vector");
  AST_WDT_ON:
    assert property ($rose(core_rst_n_o) |-> watchdog_en_o) else $error("watchdog off");
  AST_MODE_INIT:
    assert property ($rose(core_rst_n_o) |-> mode_o == SMSR_FAST_SINGLE)
      else $error("mode after reset wrong");
  AST_SLOW_OFF:
    assert property ($fell(fast_osc_en_o) |-> ##[0:2] mode_o == SMSR_SLOW_OFF)
      else $error("slow-off not reached");
  AST_EXT_IGNORE:
    assert property ($fell(reset_pin_n_i) && core_rst_n_o |-> core_rst_n_o [*8])
      else $error("short pin pulse reset");
  AST_EXT_APPLY:
    assert property ($fell(reset_pin_n_i) |-> ##[1:60] (!core_rst_n_o || reset_pin_n_i))
      else $error("pin reset not applied");
  AST_MALF_ON:
    assert property ($rose(addr_trap_i) || $rose(wdt_fault_i) |-> ##[1:2] !core_rst_n_o)
      else $error("malfunction reset missing");
  AST_MALF_LEN:
    assert property ($fell(core_rst_n_o) && reset_pin_n_i |-> ##[1:100] core_rst_n_o)
      else $error("malfunction reset too long");
  // a runt would show as two enables closer than one fast period
  AST_NO_RUNT:
    assert property (core_ce_o |=> !core_ce_o [*3]) else $error("core enable runt");
endmodule

bind smsr_top smsr_monitor smsr_monitor_i (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .reset_pin_n_i(reset_pin_n_i),
  .addr_trap_i(addr_trap_i),
  .wdt_fault_i(wdt_fault_i),
  .vec_lo_i(vec_lo_i),
  .vec_hi_i(vec_hi_i),
  .core_ce_o(core_ce_o),
  .fast_osc_en_o(fast_osc_en_o),
  .mode_o(mode_o),
  .core_rst_n_o(core_rst_n_o),
  .int_state_clear_o(int_state_clear_o),
  .pc_o(pc_o),
  .pc_load_o(pc_load_o),
  .watchdog_en_o(watchdog_en_o)
);
